//--- ssf_flag_bank.sv
// System status flag bank with Avalon-MM register access.
// Assumes fault inputs synchronous to clk; nrst low is a power cycle.
`timescale 1ns/10ps
`include "ssf_params.svh"
module ssf_flag_bank
    import ssf_pkg::*;
#(
    parameter int AC_DROP_CYC  = `SSF_AC_DROP_CYC,
    parameter int DC_DROP_CYC  = `SSF_DC_DROP_CYC,
    parameter int OP_CYCLE_CYC = `SSF_OP_CYCLE_CYC,
    parameter int MAIN_CYC     = `SSF_MAIN_PASS_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic [`SSF_ADDR_W-1:0] address,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic [31:0]            writedata,
    output logic      [31:0]            readdata,
    output logic                        waitrequest,
    input  wire logic                   fuse_fault_in,
    input  wire logic                   supply_ok_in,
    input  wire logic                   battery_below_in,
    input  wire logic                   self_diag_error_in,
    input  wire logic                   diag_error_in,
    input  wire logic                   watchdog_error_in,
    input  wire logic [15:0]            watchdog_cause_in,
    input  wire logic                   params_ok_in,
    input  wire logic                   test_request_in,
    input  wire logic                   test_grant_in,
    input  wire logic                   test_exit_in,
    input  wire logic                   forced_stop_n_in,
    input  wire logic [63:0]            clock_time_in,
    output logic                        clock_write,
    output logic      [63:0]            clock_wdata,
    output logic                        battery_indicator,
    output logic                        axis_stop
);
    localparam int DROP_W = $clog2(AC_DROP_CYC + 2);
    localparam int OP_W   = $clog2(OP_CYCLE_CYC + 1);
    localparam int MAIN_W = $clog2(MAIN_CYC + 1);

    generate
        if (DC_DROP_CYC < 1 || AC_DROP_CYC < DC_DROP_CYC || OP_CYCLE_CYC < 2 || MAIN_CYC < 2) begin : g_bad
            $error("ssf_flag_bank: timing parameters out of range");
        end
    endgenerate

    ssf_bus_state_t            bus_q;
    logic [`SSF_CT_W-1:0]      ctrl_q;
    logic [`SSF_CT_W-1:0]      ctrl_prev_q;
    ssf_word_t                 clk_word_q [`SSF_CLK_WORDS];
    ssf_word_t                 wd_cause_q;
    logic [OP_W-1:0]           op_cnt_q;
    logic [MAIN_W-1:0]         main_cnt_q;
    logic                      op_tick_q;
    logic                      main_tick_q;
    logic [DROP_W-1:0]         drop_cnt_q;
    logic                      drop_long_q;
    logic                      dropout_q;
    logic                      batt_live_q;
    logic                      const_high_q;
    logic                      const_low_q;
    logic                      ready_q;
    logic                      test_act_q;
    logic                      fstop_q;
    logic                      clk_err_q;
    logic [5:0]                sticky_set;
    logic [5:0]                sticky_clr;
    logic [5:0]                sticky_q;
    logic [`SSF_ST_W-1:0]      status;
    logic                      acc;
    logic                      wr_go;
    logic                      set_rise;
    logic                      diag_clr_rise;
    logic                      host_rise;
    logic                      batt_use;
    logic                      words_bad;
    logic [DROP_W-1:0]         drop_lim;
    logic [63:0]               words_flat;

    assign acc           = read | write;
    assign wr_go         = write & (bus_q == SSF_BUS_ACK);
    assign set_rise      = ctrl_q[`SSF_CT_CLK_SET] & ~ctrl_prev_q[`SSF_CT_CLK_SET];
    assign diag_clr_rise = ctrl_q[`SSF_CT_DIAG_CLR] & ~ctrl_prev_q[`SSF_CT_DIAG_CLR];
    assign host_rise     = ctrl_q[`SSF_CT_HOST_READY] & ~ctrl_prev_q[`SSF_CT_HOST_READY];
    assign batt_use      = ctrl_q[`SSF_CT_BATT_USE];
    assign words_flat    = {clk_word_q[3], clk_word_q[2], clk_word_q[1], clk_word_q[0]};
    assign drop_lim      = ctrl_q[`SSF_CT_DC_SUPPLY] ? DROP_W'(DC_DROP_CYC)
                                                     : DROP_W'(AC_DROP_CYC);

    // Every nibble of the clock words must be a BCD digit
    always_comb begin
        words_bad = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (words_flat[4*i +: 4] > `SSF_BCD_MAX) begin
                words_bad = 1'b1;
            end
        end
    end

    // Avalon-MM handshake: one wait cycle, answer on the second
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus_q       <= SSF_BUS_IDLE;
            waitrequest <= 1'b1;
        end else begin
            unique case (bus_q)
                SSF_BUS_IDLE: begin
                    if (acc) begin
                        bus_q       <= SSF_BUS_ACK;
                        waitrequest <= 1'b0;
                    end
                end
                SSF_BUS_ACK: begin
                    bus_q       <= SSF_BUS_IDLE;
                    waitrequest <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            readdata <= 32'h0000_0000;
        end else if (read && bus_q == SSF_BUS_IDLE) begin
            unique case (address)
                `SSF_REG_STATUS:  readdata <= 32'(status);
                `SSF_REG_CONTROL: readdata <= 32'(ctrl_q);
                `SSF_REG_CLK0:    readdata <= 32'(clk_word_q[0]);
                `SSF_REG_CLK1:    readdata <= 32'(clk_word_q[1]);
                `SSF_REG_CLK2:    readdata <= 32'(clk_word_q[2]);
                `SSF_REG_CLK3:    readdata <= 32'(clk_word_q[3]);
                `SSF_REG_WDCAUSE: readdata <= 32'(wd_cause_q);
                default:          readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Control register; the previous copy gives request edges
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_q      <= `SSF_CT_RESET; // RULE19
            ctrl_prev_q <= `SSF_CT_RESET;
        end else begin
            ctrl_prev_q <= ctrl_q;
            if (wr_go && address == `SSF_REG_CONTROL) begin
                ctrl_q <= writedata[`SSF_CT_W-1:0];
            end
        end
    end

    // Clock words: a held read request overrides software writes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < `SSF_CLK_WORDS; i++) begin
                clk_word_q[i] <= 16'h0000;
            end
        end else if (ctrl_q[`SSF_CT_CLK_READ] && main_tick_q) begin
            for (int i = 0; i < `SSF_CLK_WORDS; i++) begin
                clk_word_q[i] <= clock_time_in[16*i +: 16]; // RULE12
            end
        end else if (wr_go) begin
            for (int i = 0; i < `SSF_CLK_WORDS; i++) begin
                if (address == `SSF_ADDR_W'(`SSF_REG_CLK0 + 4*i)) begin
                    clk_word_q[i] <= writedata[15:0];
                end
            end
        end
    end

    // Invalid words are never written into the clock element
    always_ff @(posedge clk) begin
        if (!nrst) begin
            clock_write <= 1'b0;
            clock_wdata <= 64'h0000_0000_0000_0000;
            clk_err_q   <= 1'b0;
        end else begin
            clock_write <= set_rise & ~words_bad; // RULE10
            if (set_rise) begin
                clock_wdata <= words_flat;
                clk_err_q   <= words_bad; // RULE11
            end
        end
    end

    // Rate enables: operation cycle and main processing pass
    always_ff @(posedge clk) begin
        if (!nrst) begin
            op_cnt_q    <= '0;
            op_tick_q   <= 1'b0;
            main_cnt_q  <= '0;
            main_tick_q <= 1'b0;
        end else begin
            op_tick_q   <= (op_cnt_q == OP_W'(OP_CYCLE_CYC - 1)); // RULE18
            op_cnt_q    <= (op_cnt_q == OP_W'(OP_CYCLE_CYC - 1)) ? '0 : op_cnt_q + 1'b1;
            main_tick_q <= (main_cnt_q == MAIN_W'(MAIN_CYC - 1)); // RULE18
            main_cnt_q  <= (main_cnt_q == MAIN_W'(MAIN_CYC - 1)) ? '0 : main_cnt_q + 1'b1;
        end
    end

    // Dropout timer; an outage longer than the limit is a real power-off
    always_ff @(posedge clk) begin
        if (!nrst) begin
            drop_cnt_q  <= '0;
            drop_long_q <= 1'b0;
            dropout_q   <= 1'b0;
        end else if (!supply_ok_in) begin
            if (drop_cnt_q < drop_lim) begin
                drop_cnt_q <= drop_cnt_q + 1'b1;
            end else begin
                drop_long_q <= 1'b1;
            end
        end else begin
            if (drop_cnt_q != '0 && !drop_long_q) begin
                dropout_q <= 1'b1; // RULE2 RULE3
            end
            drop_cnt_q  <= '0;
            drop_long_q <= 1'b0;
        end
    end

    // Battery check runs only when the external battery is in use
    always_ff @(posedge clk) begin
        if (!nrst) begin
            batt_live_q       <= 1'b0;
            battery_indicator <= 1'b0;
        end else if (main_tick_q) begin
            batt_live_q       <= batt_use & battery_below_in; // RULE4 RULE6
            battery_indicator <= batt_use & battery_below_in; // RULE4
        end
    end

    // Latched faults: fuse, battery, self-diag, diag, watchdog, test error
    assign sticky_set = {
        test_request_in & ~test_grant_in,       // RULE16
        watchdog_error_in,                      // RULE14
        diag_error_in,                          // RULE8
        self_diag_error_in,                     // RULE7
        main_tick_q & batt_use & battery_below_in, // RULE5 RULE6
        fuse_fault_in                           // RULE1
    };
    assign sticky_clr = {5'b0_0000, 1'b0} | {2'b00, diag_clr_rise, 3'b000}; // RULE9

    ssf_sticky #(
        .WIDTH (6)
    ) u_sticky (
        .clk    (clk),
        .nrst   (nrst),
        .set_i  (sticky_set),
        .clr_i  (sticky_clr),
        .flag_q (sticky_q)
    );

    // Watchdog: stop axes at once, keep the first cause
    always_ff @(posedge clk) begin
        if (!nrst) begin
            axis_stop  <= 1'b0;
            wd_cause_q <= 16'h0000;
        end else if (watchdog_error_in) begin
            axis_stop <= 1'b1; // RULE14
            if (!sticky_q[4]) begin
                wd_cause_q <= watchdog_cause_in; // RULE14
            end
        end
    end

    // Constant flags are rewritten every main pass
    always_ff @(posedge clk) begin
        if (!nrst) begin
            const_high_q <= 1'b1;
            const_low_q  <= 1'b0;
        end else if (main_tick_q) begin
            const_high_q <= 1'b1; // RULE13
            const_low_q  <= 1'b0; // RULE13
        end
    end

    // Ready handshake with the host-ready bit
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ready_q <= 1'b0;
        end else if (!ctrl_q[`SSF_CT_HOST_READY]) begin
            ready_q <= 1'b0; // RULE15
        end else if (host_rise) begin
            ready_q <= params_ok_in; // RULE15
        end
    end

    // Test mode held while granted until the peripheral leaves it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            test_act_q <= 1'b0;
        end else if (test_request_in && test_grant_in) begin
            test_act_q <= 1'b1; // RULE16
        end else if (test_exit_in) begin
            test_act_q <= 1'b0;
        end
    end

    // Forced stop is active low at the input, flag high when released
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fstop_q <= 1'b0;
        end else if (op_tick_q) begin
            fstop_q <= forced_stop_n_in; // RULE17
        end
    end

    always_comb begin
        status                      = '0;
        status[`SSF_ST_FUSE]        = sticky_q[0];
        status[`SSF_ST_DROPOUT]     = dropout_q;
        status[`SSF_ST_BATT_LIVE]   = batt_live_q;
        status[`SSF_ST_BATT_LATCH]  = sticky_q[1];
        status[`SSF_ST_SELF_DIAG]   = sticky_q[2];
        status[`SSF_ST_DIAG]        = sticky_q[3];
        status[`SSF_ST_CLK_ERR]     = clk_err_q;
        status[`SSF_ST_CONST_HIGH]  = const_high_q;
        status[`SSF_ST_CONST_LOW]   = const_low_q;
        status[`SSF_ST_WDOG]        = sticky_q[4];
        status[`SSF_ST_READY]       = ready_q;
        status[`SSF_ST_TEST_ACT]    = test_act_q;
        status[`SSF_ST_FSTOP]       = fstop_q;
        status[`SSF_ST_TEST_ERR]    = sticky_q[5];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_set_rise;
        ctrl_q[`SSF_CT_CLK_SET] && !ctrl_prev_q[`SSF_CT_CLK_SET];
    endsequence
    sequence s_good_words;
        !words_bad;
    endsequence
    sequence s_host_up;
        !ctrl_prev_q[`SSF_CT_HOST_READY] ##1 host_rise && params_ok_in;
    endsequence

    chk_fuse_holds: assert property ( // RULE1
        fuse_fault_in |=> sticky_q[0] [*3])
        else $error("fuse flag dropped after fault");
    chk_dropout_held: assert property ( // RULE2 RULE3
        $rose(dropout_q) |=> dropout_q [*4])
        else $error("dropout flag cleared without power cycle");
    chk_batt_live: assert property ( // RULE4
        main_tick_q |=> batt_live_q == ($past(batt_use) && $past(battery_below_in))
                        && battery_indicator == batt_live_q)
        else $error("live battery flag or indicator wrong");
    chk_batt_unused: assert property ( // RULE6
        !batt_use && !sticky_q[1] |=> !sticky_q[1])
        else $error("battery latch set while battery unused");
    chk_batt_latch: assert property ( // RULE5
        main_tick_q && batt_use && battery_below_in |=> sticky_q[1] ##1 sticky_q[1])
        else $error("battery latch not held");
    chk_self_diag: assert property ( // RULE7
        self_diag_error_in |=> sticky_q[2] [*2])
        else $error("self diag flag not held");
    chk_diag_clear: assert property ( // RULE8 RULE9
        diag_clr_rise && !diag_error_in |=> !sticky_q[3])
        else $error("diag flag not cleared on request edge");
    chk_clock_write: assert property ( // RULE10 RULE11
        s_set_rise ##0 s_good_words |=> clock_write && !clk_err_q)
        else $error("clock element not written on set edge");
    chk_no_write: assert property ( // RULE10
        !set_rise |=> !clock_write)
        else $error("clock written without request edge");
    chk_constants: assert property ( // RULE13
        const_high_q && !const_low_q)
        else $error("constant flags wrong");
    chk_wd_stop: assert property ( // RULE14
        watchdog_error_in |=> axis_stop && sticky_q[4])
        else $error("watchdog did not stop axes");
    chk_ready_hs: assert property ( // RULE15
        s_host_up |=> ready_q)
        else $error("ready not set after host ready");
    chk_ready_drop: assert property ( // RULE15
        !ctrl_q[`SSF_CT_HOST_READY] |=> !ready_q)
        else $error("ready not cleared");
    chk_test_err: assert property ( // RULE16
        test_request_in && !test_grant_in |=> sticky_q[5])
        else $error("test request error not flagged");
    chk_forced_stop: assert property ( // RULE17
        op_tick_q |=> fstop_q == $past(forced_stop_n_in))
        else $error("forced stop flag not sampled");
endmodule

//--- ssf_params.svh
// Constants of the system status flag bank: register map, fields, timing.
// Assumes a 20 MHz clock and byte addresses on the Avalon-MM slave.
//
// Contract
// RULE1: Blown-fuse flag sets on any reported output fuse fault and stays set.
// RULE2: AC supply: dropout shorter than 20 ms sets dropout flag; only power cycle clears.
// RULE3: DC supply: dropout shorter than 10 ms sets dropout flag; only power cycle clears.
// RULE4: Live battery-low flag follows the comparison; battery indicator mirrors it.
// RULE5: Latched battery-low flag sets on low battery and stays set.
// RULE6: Battery check and both battery flags work only when external battery is selected.
// RULE7: Self-diagnostic error flag sets on a self-diagnosis error and stays set.
// RULE8: Diagnostic error flag sets on diagnosis error until cleared by reset request.
// RULE9: Rising edge of the diagnostic-error clear request clears the diagnostic error.
// RULE10: Rising edge of clock-set request writes the four clock words into the clock.
// RULE11: Clock data error flag reflects invalid clock words, evaluated at each set request.
// RULE12: While clock-read request is high, current BCD time is copied to the clock words.
// RULE13: One flag held high, one held low, refreshed every main processing pass.
// RULE14: Watchdog error sets its flag, stops all axes at once and stores the cause.
// RULE15: Host-ready rise checks parameters and sets ready-complete if good; fall clears it.
// RULE16: Test-mode flag high while granted; a failed test request sets request error flag.
// RULE17: Forced-stop input sampled each operation cycle; flag high when stop is inactive.
// RULE18: Operation-cycle flags refresh every operation cycle, main flags every main pass.
// RULE19: Latched faults and request-driven flags clear at power-on reset.
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH

`define SSF_CLK_PERIOD_NS   50
`define SSF_AC_DROP_US      20000
`define SSF_DC_DROP_US      10000
`define SSF_AC_DROP_CYC     ((`SSF_AC_DROP_US * 1000) / `SSF_CLK_PERIOD_NS)
`define SSF_DC_DROP_CYC     ((`SSF_DC_DROP_US * 1000) / `SSF_CLK_PERIOD_NS)
`define SSF_OP_CYCLE_US     1000
`define SSF_OP_CYCLE_CYC    ((`SSF_OP_CYCLE_US * 1000) / `SSF_CLK_PERIOD_NS)
`define SSF_MAIN_PASS_CYC   64

`define SSF_ADDR_W          5
`define SSF_REG_STATUS      5'h00
`define SSF_REG_CONTROL     5'h04
`define SSF_REG_CLK0        5'h08
`define SSF_REG_CLK1        5'h0C
`define SSF_REG_CLK2        5'h10
`define SSF_REG_CLK3        5'h14
`define SSF_REG_WDCAUSE     5'h18

`define SSF_ST_FUSE         0
`define SSF_ST_DROPOUT      1
`define SSF_ST_BATT_LIVE    2
`define SSF_ST_BATT_LATCH   3
`define SSF_ST_SELF_DIAG    4
`define SSF_ST_DIAG         5
`define SSF_ST_CLK_ERR      6
`define SSF_ST_CONST_HIGH   7
`define SSF_ST_CONST_LOW    8
`define SSF_ST_WDOG         9
`define SSF_ST_READY        10
`define SSF_ST_TEST_ACT     11
`define SSF_ST_FSTOP        12
`define SSF_ST_TEST_ERR     13
`define SSF_ST_W            14

`define SSF_CT_CLK_SET      0
`define SSF_CT_CLK_READ     1
`define SSF_CT_DIAG_CLR     2
`define SSF_CT_HOST_READY   3
`define SSF_CT_BATT_USE     4
`define SSF_CT_DC_SUPPLY    5
`define SSF_CT_W            6
`define SSF_CT_RESET        6'h00

`define SSF_BCD_MAX         4'h9
`define SSF_WORD_W          16
`define SSF_CLK_WORDS       4

`endif

//--- ssf_pkg.sv
// Types shared by the system status flag bank.
// Assumes ssf_params.svh supplies the field widths.
`include "ssf_params.svh"
package ssf_pkg;
    typedef enum logic [0:0] {
        SSF_BUS_IDLE = 1'b0,
        SSF_BUS_ACK  = 1'b1
    } ssf_bus_state_t;

    typedef logic [`SSF_WORD_W-1:0] ssf_word_t;
endpackage

//--- ssf_sticky.sv
// Vector of sticky flags: set wins over clear.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module ssf_sticky #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] clr_i,
    output logic      [WIDTH-1:0] flag_q
);
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flag_q <= '0;
        end else begin
            // An event in the clearing cycle is kept
            flag_q <= set_i | (flag_q & ~clr_i);
        end
    end
endmodule

//--- ssf_flag_bank_tb.sv
// Self-checking bench of the system status flag bank.
// Assumes the design answers each bus request by itself; small counts shorten waits.
`timescale 1ns/10ps
`include "ssf_params.svh"
module ssf_flag_bank_tb;
    import ssf_pkg::*;
    localparam int AC = 40;
    localparam int DC = 20;
    localparam int OP = 8;
    localparam int MC = 4;
    logic        clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
    logic [4:0]  address = 5'h00;
    logic [31:0] writedata = 32'h0000_0000, readdata, r;
    logic        waitrequest, clock_write, battery_indicator, axis_stop;
    logic        fuse = 0, sup = 1, batt = 0, sdiag = 0, diag = 0, wdog = 0, pok = 0;
    logic        treq = 0, tgnt = 0, texit = 0, fstop_n = 1;
    logic [15:0] cause = 16'h0000, b;
    logic [63:0] ctime = 64'h0, clock_wdata, w;
    logic [31:0] lfsr = 32'h9b4b_ba47;
    logic [63:0] rq[$];
    logic [63:0] cq[$];
    int          n_mismatch = 0, num_checks = 0, i, j, k;

    always #25 clk = ~clk;

    ssf_flag_bank #(.AC_DROP_CYC(AC), .DC_DROP_CYC(DC), .OP_CYCLE_CYC(OP), .MAIN_CYC(MC)) u_dut (
        .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .fuse_fault_in(fuse), .supply_ok_in(sup), .battery_below_in(batt),
        .self_diag_error_in(sdiag), .diag_error_in(diag), .watchdog_error_in(wdog),
        .watchdog_cause_in(cause), .params_ok_in(pok), .test_request_in(treq),
        .test_grant_in(tgnt), .test_exit_in(texit), .forced_stop_n_in(fstop_n),
        .clock_time_in(ctime), .clock_write(clock_write), .clock_wdata(clock_wdata),
        .battery_indicator(battery_indicator), .axis_stop(axis_stop));

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic end_sim();
        if (rq.size() != 0 || cq.size() != 0)
            n_mismatch++;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Request held until waitrequest is sampled low at a rising edge; released at that edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (waitrequest === 1'b0)
                break;
        end
        read <= 1'b0;
        write <= 1'b0;
        if (n == 20) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        rq.push_back({e, m});
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic do_rst();
        nrst <= 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
    endtask

    // Monitor: each answer takes the oldest note; a stray pulse meets an empty queue
    always @(negedge clk) begin
        logic [63:0] e;
        if (read && waitrequest === 1'b0) begin
            e = (rq.size() != 0) ? rq.pop_front() : 64'hffff_ffff_ffff_ffff;
            chk(64'(readdata & e[31:0]), 64'(e[63:32]), "read");
        end
        if (clock_write === 1'b1) begin
            e = (cq.size() != 0) ? cq.pop_front() : ~clock_wdata;
            chk(clock_wdata, e, "clock write");
        end
    end

    initial begin
        do_rst();
        cyc(2 * OP);
        rd(`SSF_REG_STATUS, 32'h0000_1080, 32'h0000_3fff);
        rd(5'h1c, 32'h0000_0000, 32'hffff_ffff);
        bus(1'b1, `SSF_REG_STATUS, 32'hffff_ffff);
        rd(`SSF_REG_STATUS, 32'h0000_1080, 32'h0000_3fff);
        $display("test reset done");
        r = rnd();
        @(posedge clk);
        {fuse, sdiag, diag, wdog} <= 4'hf;
        cause <= r[15:0];
        @(posedge clk);
        {fuse, sdiag, diag, wdog} <= 4'h0;
        cause <= ~r[15:0];
        cyc(2);
        chk(64'(axis_stop), 64'h1, "axis stop");
        rd(`SSF_REG_STATUS, 32'h0000_0231, 32'h0000_0231);
        rd(`SSF_REG_WDCAUSE, {16'h0000, r[15:0]}, 32'h0000_ffff);
        bus(1'b1, `SSF_REG_CONTROL, 32'h0000_0004);
        rd(`SSF_REG_STATUS, 32'h0000_0211, 32'h0000_0231);
        $display("test faults done");
        batt <= 1'b1;
        bus(1'b1, `SSF_REG_CONTROL, 32'h0000_0000);
        cyc(3 * MC);
        rd(`SSF_REG_STATUS, 32'h0000_0000, 32'h0000_000c);
        bus(1'b1, `SSF_REG_CONTROL, 32'h0000_0010);
        cyc(3 * MC);
        rd(`SSF_REG_STATUS, 32'h0000_000c, 32'h0000_000c);
        chk(64'(battery_indicator), 64'h1, "indicator");
        batt <= 1'b0;
        cyc(3 * MC);
        rd(`SSF_REG_STATUS, 32'h0000_0008, 32'h0000_000c);
        chk(64'(battery_indicator), 64'h0, "indicator");
        $display("test battery done");
        for (k = 0; k < 2; k++) begin
            for (i = 0; i < 4; i++) begin
                r = rnd();
                for (j = 0; j < 4; j++)
                    b[4*j+:4] = r[4*j+:4] % 4'd10;
                if (k == 1 && i == 0)
                    b[15:12] = 4'ha;
                w[16*i+:16] = b;
                bus(1'b1, 5'(8 + 4 * i), {16'h0000, b});
            end
            if (k == 0)
                cq.push_back(w);
            bus(1'b1, `SSF_REG_CONTROL, 32'h0000_0000);
            bus(1'b1, `SSF_REG_CONTROL, 32'h0000_0001);
            cyc(4);
            rd(`SSF_REG_STATUS, (k == 1) ? 32'h0000_0040 : 32'h0000_0000, 32'h0000_0040);
        end
        ctime <= {rnd(), rnd()};
        bus(1'b1, `SSF_REG_CONTROL, 32'h0000_0002);
        cyc(3 * MC);
        for (i = 0; i < 4; i++)
            rd(5'(8 + 4 * i), {16'h0000, ctime[16*i+:16]}, 32'h0000_ffff);
        $display("test clock done");
        for (k = 0; k < 2; k++) begin
            pok <= k[0];
            bus(1'b1, `SSF_REG_CONTROL, 32'h0000_0008);
            rd(`SSF_REG_STATUS, {21'h0, k[0], 10'h0}, 32'h0000_0400);
            bus(1'b1, `SSF_REG_CONTROL, 32'h0000_0000);
            rd(`SSF_REG_STATUS, 32'h0000_0000, 32'h0000_0400);
        end
        for (k = 1; k >= 0; k--) begin
            @(posedge clk);
            treq <= 1'b1;
            tgnt <= k[0];
            @(posedge clk);
            treq <= 1'b0;
            cyc(2);
            rd(`SSF_REG_STATUS, k[0] ? 32'h0000_0800 : 32'h0000_2000, 32'h0000_2800);
            texit <= 1'b1;
            @(posedge clk);
            texit <= 1'b0;
        end
        fstop_n <= 1'b0;
        cyc(2 * OP + 2);
        rd(`SSF_REG_STATUS, 32'h0000_0000, 32'h0000_1000);
        $display("test requests done");
        for (k = 0; k < 2; k++) begin
            do_rst();
            bus(1'b1, `SSF_REG_CONTROL, {26'h0, k[0], 5'h00});
            sup <= 1'b0;
            cyc(((k == 1) ? DC : AC) + 5);
            sup <= 1'b1;
            cyc(3);
            rd(`SSF_REG_STATUS, 32'h0000_0000, 32'h0000_0002);
            sup <= 1'b0;
            cyc(((k == 1) ? DC : AC) / 2);
            sup <= 1'b1;
            cyc(3);
            rd(`SSF_REG_STATUS, 32'h0000_0002, 32'h0000_0002);
        end
        $display("test dropout done");
        cyc(4);
        end_sim();
    end
endmodule
